// ==== include/sd_err_pkg.sv ====
// constants, register map and state codes of the command/data error flags
// assumes nothing beyond a SystemVerilog compiler that reads packages first
package sd_err_pkg;

   // register port widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // register offsets (byte addresses, one aligned word each)
   localparam logic [ADDR_W-1:0] ADDR_FLAGS  = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_ENABLE = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_ARG    = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_CMD    = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_RSP    = 8'h10;

   // error flag layout
   localparam int FLAG_W       = 5;
   localparam int BIT_CMD_TOUT = 0;
   localparam int BIT_CMD_CRC  = 1;
   localparam int BIT_CMD_END  = 2;
   localparam int BIT_CMD_IDX  = 3;
   localparam int BIT_DAT_TOUT = 4;
   localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h00;

   // command control word layout
   localparam int IDX_W        = 6;
   localparam int CTL_RSP_BIT  = 8;
   localparam int CTL_BUSY_BIT = 9;

   // frame layout on the command line
   localparam int FRAME_W = 48;
   localparam int CRC_W   = 7;
   localparam int ARG_W   = 32;
   localparam logic [5:0] FRAME_BITS = 6'h30;  // 48 bits per frame
   localparam logic [5:0] FRAME_LAST = 6'h2f;
   localparam logic [5:0] CRC_SPAN   = 6'h28;  // bits covered by crc
   localparam logic [CRC_W-1:0] CRC_POLY = 7'h09;
   localparam logic [1:0] FRAME_HEAD = 2'h1;   // start 0, direction 1

   // response window in link clock cycles after the end bit
   localparam int RSP_WAIT_CYCLES = 64;

   // command sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01,
      ST_WAIT = 2'b10,
      ST_RECV = 2'b11
   } cmd_state_e;

endpackage

// ==== hdl/bit_sync.sv ====
// two flip-flop synchroniser for levels from outside the clock domain
// assumes the input is a slow level compared with clk
`timescale 1ns/1ps
module bit_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] din,
   output      logic [WIDTH-1:0] dout
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] safe;
   } sync_s;

   sync_s r;
   sync_s next_r;

   // first stage feeds the second stage only
   always_comb begin
      next_r      = r;
      next_r.meta = din;
      next_r.safe = r.meta;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign dout = r.safe;

endmodule

// ==== hdl/crc7_step.sv ====
// one serial step of the 7-bit command crc
// assumes the caller holds the crc register and chooses the input bit
`timescale 1ns/1ps
module crc7_step
   import sd_err_pkg::*;
(
   input  wire logic [sd_err_pkg::CRC_W-1:0] crc_in,
   input  wire logic                         bit_in,
   output      logic [sd_err_pkg::CRC_W-1:0] crc_out
);
   import sd_err_pkg::*;

   logic feedback;

   // shift left, fold the polynomial in when the feedback is one
   always_comb begin
      feedback = bit_in ^ crc_in[CRC_W-1];
      crc_out  = {crc_in[CRC_W-2:0], 1'b0} ^ (feedback ? CRC_POLY : '0);
   end

endmodule

// ==== hdl/sd_cmd_err_flags.sv ====
// command sequencer with error detection and sticky error flags
// assumes sdclk_pin and cmd_in come from pins, the data timeout pulses
// come from data path logic on clk, and an outside wire resolves cmd
// Functional notes
// - Data timeout flag sets on busy, write crc status or read timeout.
// - Command index flag sets when the response index differs.
// - Command end bit flag sets when the response end bit is zero.
// - Command crc flag sets on a response crc mismatch without timeout.
// - A driven one read back as zero aborts the command and sets crc.
// - That conflict also sets the command timeout flag.
// - Apart from a conflict, command timeout sets only after RSP_WAIT link cycles (64 by default) with no response.
// - On a conflict the timeout flag sets at once, without the window.
// - The crc and timeout pair encodes none, timeout, crc or conflict.
// - Writing one clears a flag, zero leaves it, several at once.
// - Interrupt is high while an enabled flag is set.
`timescale 1ns/1ps
module sd_cmd_err_flags
   import sd_err_pkg::*;
#(
   parameter int RSP_WAIT = sd_err_pkg::RSP_WAIT_CYCLES
) (
   input  wire logic                          clk,
   input  wire logic                          nrst,
   input  wire logic                          sdclk_pin,
   input  wire logic                          cmd_in,
   output      logic                          cmd_out,
   output      logic                          cmd_oe,
   input  wire logic [sd_err_pkg::ADDR_W-1:0] addr,
   input  wire logic [sd_err_pkg::DATA_W-1:0] wdata,
   input  wire logic                          wr,
   input  wire logic                          rd,
   output      logic [sd_err_pkg::DATA_W-1:0] rdata,
   input  wire logic                          busy_timeout_r1b,
   input  wire logic                          busy_timeout_wr,
   input  wire logic                          crc_status_timeout,
   input  wire logic                          read_data_timeout,
   output      logic                          irq
);
   import sd_err_pkg::*;

   localparam logic [5:0] WAIT_LAST = 6'(RSP_WAIT - 1);

   ////////////////////////////////////////////////////////////////////////
   // parameter check
   initial begin
      if (RSP_WAIT < 2 || RSP_WAIT > 64) begin
         $error("response window must lie between 2 and 64");
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      cmd_state_e           state;
      logic [5:0]           bitcnt;
      logic [5:0]           waitcnt;
      logic [CRC_W-1:0]     crc;
      logic [FRAME_W-1:0]   shreg;
      logic                 line_out;
      logic                 line_oe;
      logic                 expect_rsp;
      logic [IDX_W-1:0]     idx;
      logic [ARG_W-1:0]     arg;
      logic [ARG_W-1:0]     rsp;
      logic [FLAG_W-1:0]    flags;
      logic [FLAG_W-1:0]    enable;
      logic [DATA_W-1:0]    rd_word;
      logic                 irq_q;
      logic                 clk_prev;
   } err_s;

   err_s r;
   err_s next_r;

   logic [1:0]         sync_out;
   logic               clk_s;
   logic               cmd_s;
   logic               rise;
   logic               fall;
   logic               crc_bit;
   logic [CRC_W-1:0]   crc_next;
   logic [FLAG_W-1:0]  set;
   logic [FLAG_W-1:0]  clr;
   logic               conflict;
   logic               rsp_done;
   logic [FRAME_W-1:0] frame;
   logic               start;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and crc step
   bit_sync #(
      .WIDTH (2)
   ) pin_sync (
      .clk  (clk),
      .nrst (nrst),
      .din  ({sdclk_pin, cmd_in}),
      .dout (sync_out)
   );

   assign clk_s = sync_out[1];
   assign cmd_s = sync_out[0];

   // transmit bits while sending, line bits while receiving
   assign crc_bit = (r.state == ST_SEND) ? r.shreg[FRAME_W-1] : cmd_s;

   crc7_step crc_unit (
      .crc_in  (r.crc),
      .bit_in  (crc_bit),
      .crc_out (crc_next)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_r          = r;
      set             = '0;
      clr             = '0;
      conflict        = 1'b0;
      rsp_done        = 1'b0;
      frame           = {r.shreg[FRAME_W-2:0], cmd_s};
      rise            = clk_s & ~r.clk_prev;
      fall            = ~clk_s & r.clk_prev;
      start           = wr && addr == ADDR_CMD && r.state == ST_IDLE;
      next_r.clk_prev = clk_s;

      // data path timeouts, any of four
      set[BIT_DAT_TOUT] = busy_timeout_r1b | busy_timeout_wr |
                          crc_status_timeout | read_data_timeout;

      // command sequencer
      case (r.state)
         ST_IDLE: begin
            if (start) begin
               next_r.state      = ST_SEND;
               next_r.bitcnt     = '0;
               next_r.crc        = '0;
               next_r.idx        = wdata[IDX_W-1:0];
               next_r.expect_rsp = wdata[CTL_RSP_BIT];
               next_r.shreg      = {FRAME_HEAD, wdata[IDX_W-1:0], r.arg,
                                    8'h00};
            end
         end
         ST_SEND: begin
            if (rise && r.line_oe && r.line_out && !cmd_s) begin
               conflict          = 1'b1;
               next_r.line_oe    = 1'b0;
               next_r.line_out   = 1'b1;
               next_r.state      = ST_IDLE;
               set[BIT_CMD_CRC]  = 1'b1;
               set[BIT_CMD_TOUT] = 1'b1;
            end else if (fall) begin
               if (r.bitcnt == FRAME_BITS) begin
                  next_r.line_oe  = 1'b0;
                  next_r.line_out = 1'b1;
                  next_r.waitcnt  = '0;
                  next_r.crc      = '0;
                  next_r.state    = r.expect_rsp ? ST_WAIT : ST_IDLE;
               end else begin
                  next_r.line_oe = 1'b1;
                  next_r.bitcnt  = r.bitcnt + 6'h01;
                  if (r.bitcnt < CRC_SPAN) begin
                     next_r.line_out = r.shreg[FRAME_W-1];
                     next_r.shreg    = {r.shreg[FRAME_W-2:0], 1'b0};
                     next_r.crc      = crc_next;
                  end else if (r.bitcnt < FRAME_LAST) begin
                     next_r.line_out = r.crc[CRC_W-1];
                     next_r.crc      = {r.crc[CRC_W-2:0], 1'b0};
                  end else begin
                     next_r.line_out = 1'b1;  // end bit
                  end
               end
            end
         end
         ST_WAIT: begin
            if (rise) begin
               if (!cmd_s) begin
                  next_r.state  = ST_RECV;
                  next_r.bitcnt = 6'h01;
                  next_r.shreg  = frame;
                  next_r.crc    = crc_next;
               end else if (r.waitcnt == WAIT_LAST) begin
                  set[BIT_CMD_TOUT] = 1'b1;
                  next_r.state      = ST_IDLE;
               end else begin
                  next_r.waitcnt = r.waitcnt + 6'h01;
               end
            end
         end
         ST_RECV: begin
            if (rise) begin
               next_r.shreg  = frame;
               next_r.bitcnt = r.bitcnt + 6'h01;
               if (r.bitcnt < CRC_SPAN) begin
                  next_r.crc = crc_next;
               end
               if (r.bitcnt == FRAME_LAST) begin
                  rsp_done     = 1'b1;
                  next_r.state = ST_IDLE;
                  next_r.rsp   = frame[ARG_W+CRC_W:CRC_W+1];
                  set[BIT_CMD_END] = ~cmd_s;
                  set[BIT_CMD_IDX] =
                     frame[FRAME_W-3:FRAME_W-2-IDX_W] != r.idx;
                  // a response arrived, so this command had no timeout
                  set[BIT_CMD_CRC] = frame[CRC_W:1] != r.crc;
               end
            end
         end
         default: begin
            next_r.state = ST_IDLE;
         end
      endcase

      // register writes
      if (wr) begin
         case (addr)
            ADDR_FLAGS:  clr = wdata[FLAG_W-1:0];
            ADDR_ENABLE: next_r.enable = wdata[FLAG_W-1:0];
            ADDR_ARG:    next_r.arg = wdata;
            default: begin
            end
         endcase
      end

      // sticky flags, a set in the clearing cycle wins
      next_r.flags = (r.flags & ~clr) | set;

      // interrupt level from the enabled flags
      next_r.irq_q = |(r.flags & r.enable);

      // read data stand in the cycle after the strobe only
      next_r.rd_word = '0;
      if (rd) begin
         case (addr)
            ADDR_FLAGS:  next_r.rd_word = 32'(r.flags);
            ADDR_ENABLE: next_r.rd_word = 32'(r.enable);
            ADDR_ARG:    next_r.rd_word = r.arg;
            ADDR_CMD: begin
               next_r.rd_word[IDX_W-1:0]   = r.idx;
               next_r.rd_word[CTL_RSP_BIT]  = r.expect_rsp;
               next_r.rd_word[CTL_BUSY_BIT] = r.state != ST_IDLE;
            end
            ADDR_RSP:    next_r.rd_word = r.rsp;
            default:     next_r.rd_word = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r          <= '0;
         r.state    <= ST_IDLE;
         r.line_out <= 1'b1;
         r.flags    <= FLAGS_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign cmd_out = r.line_out;
   assign cmd_oe  = r.line_oe;
   assign rdata   = r.rd_word;
   assign irq     = r.irq_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   data_timeout_a: assert property (
      @(posedge clk) disable iff (!nrst)
      (busy_timeout_r1b || busy_timeout_wr || crc_status_timeout ||
       read_data_timeout) |=> r.flags[BIT_DAT_TOUT])
      else $error("data timeout flag missed");

   index_fault_a: assert property (
      @(posedge clk) disable iff (!nrst)
      (rsp_done && frame[FRAME_W-3:FRAME_W-2-IDX_W] != r.idx)
      |=> r.flags[BIT_CMD_IDX])
      else $error("index fault flag missed");

   end_bit_a: assert property (
      @(posedge clk) disable iff (!nrst)
      (rsp_done && !cmd_s) |=> r.flags[BIT_CMD_END])
      else $error("end bit fault flag missed");

   rsp_crc_a: assert property (
      @(posedge clk) disable iff (!nrst)
      (rsp_done && frame[CRC_W:1] != r.crc) |=> r.flags[BIT_CMD_CRC])
      else $error("response crc flag missed");

   conflict_abort_a: assert property (
      @(posedge clk) disable iff (!nrst)
      (r.state == ST_SEND && rise && r.line_oe && r.line_out && !cmd_s)
      |=> !cmd_oe && r.state == ST_IDLE && r.flags[BIT_CMD_CRC])
      else $error("conflict did not abort the command");

   conflict_pair_a: assert property (
      @(posedge clk) disable iff (!nrst)
      conflict |=> r.flags[BIT_CMD_TOUT] && r.flags[BIT_CMD_CRC])
      else $error("conflict did not set both flags");

   timeout_window_a: assert property (
      @(posedge clk) disable iff (!nrst)
      (set[BIT_CMD_TOUT] && !conflict)
      |-> r.state == ST_WAIT && r.waitcnt == WAIT_LAST && rise && cmd_s)
      else $error("timeout set outside the response window");

   conflict_fast_a: assert property (
      @(posedge clk) disable iff (!nrst)
      conflict |-> r.state == ST_SEND ##1 r.flags[BIT_CMD_TOUT])
      else $error("timeout after conflict was delayed");

   flag_clear_a: assert property (
      @(posedge clk) disable iff (!nrst)
      (wr && addr == ADDR_FLAGS)
      |=> (r.flags & $past(wdata[FLAG_W-1:0]) & ~$past(set)) == '0)
      else $error("written one did not clear a flag");

   irq_level_a: assert property (
      @(posedge clk) disable iff (!nrst)
      ##1 irq == $past(|(r.flags & r.enable)))
      else $error("interrupt does not follow enabled flags");

   flag_hold_a: assert property (
      @(posedge clk) disable iff (!nrst)
      !(wr && addr == ADDR_FLAGS) |=> (r.flags & $past(r.flags)) ==
                                       $past(r.flags))
      else $error("flag dropped without a clearing write");

endmodule

// ==== verif/sd_card_model.sv ====
// behavioural card on the command line: takes a frame, answers per mode
// assumes an open-drain style wire with pull-up resolved by the bench
`timescale 1ns/1ps
module sd_card_model #(
   parameter logic [31:0] RSP_ARG = 32'h5a3c0f96
) (
   input  wire logic        sdclk,
   input  wire logic        cmd,
   input  wire logic [2:0]  mode,
   output      logic        card_oe,
   output      logic        card_out,
   output      logic [47:0] last_cmd
);
   logic [47:0] tx;
   logic [5:0]  idx;

   // serial crc7, x^7+x^3+1, init 0, msb first
   function automatic logic [6:0] crc7(input logic [39:0] d);
      logic [6:0] c;
      logic       fb;
      c = 7'h00;
      for (int k = 39; k >= 0; k--) begin
         fb = d[k] ^ c[6];
         c = {c[5:0], 1'b0};
         if (fb) c = c ^ 7'h09;
      end
      return c;
   endfunction

   // modes: 0 silent, 1 good, 2 bad index, 3 bad end, 4 bad crc, 5 clash
   initial begin
      card_oe = 1'b0;
      card_out = 1'b1;
      last_cmd = 48'h0;
      forever begin
         @(posedge sdclk);
         if (cmd === 1'b0) begin
            if (mode == 3'h5) begin
               @(negedge sdclk);
               card_oe = 1'b1; // pull low under a driven one
               card_out = 1'b0;
               // hold past the host's sampling, then let go so a
               // stopped link clock cannot leave the card driving
               @(posedge sdclk);
               #200;
               card_oe = 1'b0;
            end else begin
               last_cmd = 48'h0;
               for (int i = 0; i < 47; i++) begin
                  @(posedge sdclk);
                  last_cmd = {last_cmd[46:0], cmd};
               end
               if (mode != 3'h0) begin
                  idx = last_cmd[45:40] ^ {5'h0, mode == 3'h2};
                  tx[47:8] = {2'b00, idx, RSP_ARG};
                  tx[7:1] = crc7(tx[47:8]) ^ {6'h0, mode == 3'h4};
                  tx[0] = (mode != 3'h3);
                  @(negedge sdclk); // host lets go of the line here
                  for (int i = 47; i >= 0; i--) begin
                     @(negedge sdclk);
                     card_oe  = 1'b1;
                     card_out = tx[i];
                  end
                  // let go once the end bit has been sampled, so a
                  // stopped link clock cannot leave the card driving
                  @(posedge sdclk);
                  #200;
                  card_oe = 1'b0; // released line floats to pull-up
               end
            end
         end
      end
   end
endmodule

// ==== verif/sd_cmd_err_flags_tb.sv ====
// register-level bench for the command/data error flags
// assumes the card model answers on the pulled-up command wire
`timescale 1ns/1ps
module sd_cmd_err_flags_tb;
   import sd_err_pkg::*;
   localparam logic [31:0] RSP_ARG = 32'h5a3c0f96;
   logic                clk = 1'b0;
   logic                nrst = 1'b0;
   logic                sdclk_pin = 1'b1;
   logic                sd_run = 1'b0;
   logic                cmd_out;
   logic                cmd_oe;
   logic                card_oe;
   logic                card_out;
   logic                cmd_line;
   logic [ADDR_W-1:0]   addr = 8'h00;
   logic [DATA_W-1:0]   wdata = 32'h0;
   logic                wr = 1'b0;
   logic                rd = 1'b0;
   logic [DATA_W-1:0]   rdata;
   logic [3:0]          dto = 4'h0;
   logic                irq;
   logic [2:0]          mode = 3'h0;
   logic                want_rsp = 1'b1;
   logic [47:0]         last_cmd;
   logic [DATA_W-1:0]   d;
   int                  errors = 0;
   int                  checks = 0;
   realtime             t0;

   ////////////////////////////////////////////////////////////////////
   // clocks, unrelated phases; link clock runs only during commands
   always #50 clk = ~clk;
   always begin
      #400;
      if (sd_run) sdclk_pin = ~sdclk_pin;
   end
   assign cmd_line = (cmd_oe ? cmd_out : 1'b1) & (card_oe ? card_out : 1'b1);

   sd_cmd_err_flags #(.RSP_WAIT(4)) uut (
      .clk(clk), .nrst(nrst), .sdclk_pin(sdclk_pin), .cmd_in(cmd_line),
      .cmd_out(cmd_out), .cmd_oe(cmd_oe), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .busy_timeout_r1b(dto[0]),
      .busy_timeout_wr(dto[1]), .crc_status_timeout(dto[2]),
      .read_data_timeout(dto[3]), .irq(irq));
   sd_card_model #(.RSP_ARG(RSP_ARG)) card (
      .sdclk(sdclk_pin), .cmd(cmd_line), .mode(mode), .card_oe(card_oe),
      .card_out(card_out), .last_cmd(last_cmd));

   ////////////////////////////////////////////////////////////////////
   // bus tasks and comparison
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic chk(input string n, input logic [47:0] e,
                      input logic [47:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic flags_are(input logic [31:0] e);
      rd_reg(ADDR_FLAGS);
      chk("flags", e, {16'h0, d});
   endtask
   // start a command, poll busy under a bound
   task automatic run_cmd(input logic [2:0] m, input logic [5:0] idx);
      int n;
      mode = m;
      sd_run = 1'b1;
      t0 = $realtime;
      wr_reg(ADDR_CMD, {23'h0, want_rsp, 2'h0, idx});
      for (n = 0; n < 1000; n++) begin
         rd_reg(ADDR_CMD);
         if (d[9] === 1'b0) break;
      end
      if (n == 1000) chk("busy", 48'h0, 48'h1);
      sd_run = 1'b0;
      $display("test command mode %0d done", m);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // watchdog
   initial begin
      #3ms;
      errors++;
      report_and_stop();
   end

   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      flags_are(32'h0);
      rd_reg(ADDR_ENABLE);
      chk("enable", 48'h0, {16'h0, d});
      chk("irq", 48'h0, {47'h0, irq});
      rd_reg(8'h20);
      chk("unmapped", 48'h0, {16'h0, d});
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         dto <= 4'h1 << i;
         @(posedge clk);
         dto <= 4'h0;
         flags_are(32'h10);
         wr_reg(ADDR_FLAGS, 32'h0f);
         flags_are(32'h10);
         wr_reg(ADDR_FLAGS, 32'h10);
         flags_are(32'h0);
      end
      $display("test data timeouts done");
      wr_reg(ADDR_ARG, 32'hc0ffee11);
      run_cmd(3'h1, 6'h11);
      chk("frame", {2'b01, 6'h11, 32'hc0ffee11,
         card.crc7({2'b01, 6'h11, 32'hc0ffee11}), 1'b1}, last_cmd);
      flags_are(32'h0);
      rd_reg(ADDR_RSP);
      chk("rsp", {16'h0, RSP_ARG}, {16'h0, d});
      run_cmd(3'h2, 6'h2a);
      flags_are(32'h08);
      run_cmd(3'h1, 6'h05);
      flags_are(32'h08);
      run_cmd(3'h3, 6'h05);
      flags_are(32'h0c);
      wr_reg(ADDR_FLAGS, 32'h0c);
      flags_are(32'h0);
      run_cmd(3'h4, 6'h3f);
      flags_are(32'h02);
      wr_reg(ADDR_ENABLE, 32'h02);
      repeat (2) @(posedge clk);
      chk("irq", 48'h1, {47'h0, irq});
      wr_reg(ADDR_ENABLE, 32'h01);
      repeat (2) @(posedge clk);
      chk("irq", 48'h0, {47'h0, irq});
      wr_reg(ADDR_FLAGS, 32'h02);
      run_cmd(3'h0, 6'h01);
      flags_are(32'h01);
      chk("irq", 48'h1, {47'h0, irq});
      wr_reg(ADDR_FLAGS, 32'h01);
      // no response wanted: the silent card must not raise a timeout
      want_rsp = 1'b0;
      run_cmd(3'h0, 6'h07);
      want_rsp = 1'b1;
      chk("cmd word", 48'h07, {16'h0, d});
      flags_are(32'h0);
      run_cmd(3'h5, 6'h00);
      chk("abort", 48'h1, {47'h0, ($realtime - t0) < 12800.0});
      chk("cmd_oe", 48'h0, {47'h0, cmd_oe});
      flags_are(32'h03);
      chk("irq", 48'h1, {47'h0, irq});
      // reset in mid-run wipes flags and the interrupt
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      flags_are(32'h0);
      chk("irq", 48'h0, {47'h0, irq});
      $display("test reset in mid-run done");
      report_and_stop();
   end
endmodule
